// ---- verilog/wdt_defines.svh ----
/*
 * Register map, field positions, reset values, command codes and timing
 * figures of the watchdog timer unit.
 * Assumes a 20 MHz core clock and a 32.768 kHz low-frequency time base.
 */
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define WDT_SETUP_OFS 4'h0
`define WDT_CMD_OFS 4'h4
`define WDT_STAT_OFS 4'h8

// ----------------------------------------------------------------------
// setup register fields and reset values
// ----------------------------------------------------------------------
`define WDT_ACTION_BIT 0
`define WDT_PERIOD_LSB 1
`define WDT_PERIOD_MSB 2
`define WDT_RUN_BIT 3
`define WDT_RUN_RST 1'h1
`define WDT_ACTION_RST 1'h1
`define WDT_PERIOD_RST 2'h0

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define WDT_CLEAR_CODE 8'h4e
`define WDT_DISABLE_CODE 8'hb1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define WDT_CLK_HZ 20000000
`define WDT_CLK_NS 50
`define WDT_FS_HZ 32768
`define WDT_DET0_US 4000000
`define WDT_DET1_US 1000000
`define WDT_DET2_US 250000
`define WDT_DET3_US 62500
`define WDT_TICKS(us) ((us) * 64'd32768 / 64'd1000000)
`define WDT_TICK_DIV (`WDT_CLK_HZ / `WDT_FS_HZ)
`define WDT_RST_MIN_NS 640
`define WDT_RST_CYCLES ((`WDT_RST_MIN_NS + `WDT_CLK_NS - 1) / `WDT_CLK_NS)

`endif

// ---- verilog/wdt_pkg.sv ----
/*
 * Types of the watchdog timer unit.
 * Assumes the constants of wdt_defines.svh.
 */
package wdt_pkg;

	typedef enum logic {
		RST_IDLE,
		RST_DRIVE
	} wdt_rst_state_t;

endpackage

// ---- verilog/wdt_watchdog_timer.sv ----
/*
 * Watchdog timer unit: prescaler, binary counter, guarded disable,
 * overflow action (reset pulse or pseudo non-maskable interrupt) and
 * a classic Wishbone slave for its registers.
 * Assumes stopMode, idleMode, slowMode and the interrupt controller
 * handshakes are synchronous to core_clk; the reset pin is open drain.
 */
// The Wishbone slave port and the address map are this design's own decisions.
// Summary of operation
// - overflow action chosen once, defaults reset
// - interrupt mode doubles as interval timer
// - run enable bit 3, resets to one
// - output fires on counter overflow edge
// - action one: pull reset pin low
// - action zero: raise watchdog interrupt
// - clear code 4EH clears counter
// - two-bit field picks four overflow periods
// - counter holds in stop and idle
// - disable needs enable cleared, then B1H
// - B1H ignored while run enable set
// - disabling clears counter to zero
// - interrupt ignores enable mask register
// - new interrupt waits for nmi return
// - reset pin low about 8-24 fc periods
// - reset in slow mode starts fast oscillator
`timescale 1ns/100ps
`include "wdt_defines.svh"

module wdt_watchdog_timer #(
	parameter int TICK_DIV = `WDT_TICK_DIV,
	parameter int PERIOD0 = int'(`WDT_TICKS(`WDT_DET0_US)),
	parameter int PERIOD1 = int'(`WDT_TICKS(`WDT_DET1_US)),
	parameter int PERIOD2 = int'(`WDT_TICKS(`WDT_DET2_US)),
	parameter int PERIOD3 = int'(`WDT_TICKS(`WDT_DET3_US)),
	parameter int RST_CYCLES = `WDT_RST_CYCLES,
	parameter int CNT_W = 17
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic stopMode,
	input wire logic idleMode,
	input wire logic slowMode,
	input wire logic irqAccept,
	input wire logic softIrqAccept,
	input wire logic nmiReturnDone,
	output logic watchdogIrq,
	output logic sysResetReq,
	output logic resetPinOut,
	output logic resetPinOe,
	output logic hfOscOn
);

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (TICK_DIV < 1 || TICK_DIV > 65535)
		$error("TICK_DIV out of range");
	if (PERIOD0 < 2 || PERIOD1 < 2 || PERIOD2 < 2 || PERIOD3 < 2)
		$error("detection periods must be at least 2 ticks");
	if (PERIOD0 > 2 ** CNT_W || PERIOD1 > 2 ** CNT_W ||
	    PERIOD2 > 2 ** CNT_W || PERIOD3 > 2 ** CNT_W)
		$error("CNT_W too narrow for detection periods");
	if (RST_CYCLES < 1 || RST_CYCLES > 255)
		$error("RST_CYCLES out of range");
	// status word leaves 17 bits for the counter
	if (CNT_W < 2 || CNT_W > 17)
		$error("CNT_W must be 2 to 17");

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic ack_reg;
	logic [31:0] rdData_reg;
	logic busReq;
	logic wrByte0;
	logic [7:0] wrByte;
	logic setupWr;
	logic cmdWr;
	logic clearCmd;
	logic disableCmd;
	logic runEnable_reg;
	logic [1:0] periodSel_reg;
	logic actionSel_reg;
	logic actionLock_reg;
	logic active_reg;
	logic [15:0] prescale_reg;
	logic tick_reg;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] lastCount;
	logic hold;
	logic overflow;
	logic pending_reg;
	logic inService_reg;
	logic irq_reg;
	wdt_pkg::wdt_rst_state_t rstState_reg;
	logic [7:0] rstCount_reg;
	logic sysReset_reg;
	logic pinOe_reg;
	logic pinOut_reg;
	logic hfOsc_reg;

	// ------------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------------
	// one-cycle answer; the request is not seen again while ack is high,
	// so a held request cannot be taken twice
	assign busReq = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wrByte0 = busReq && wb_we_i && wb_sel_i[0];
	assign wrByte = wb_dat_i[7:0];
	assign setupWr = wrByte0 && (wb_adr_i == `WDT_SETUP_OFS);
	assign cmdWr = wrByte0 && (wb_adr_i == `WDT_CMD_OFS);
	assign clearCmd = cmdWr && (wrByte == `WDT_CLEAR_CODE);
	// disable honoured only once run enable is already low
	assign disableCmd = cmdWr && (wrByte == `WDT_DISABLE_CODE) &&
	                    !runEnable_reg;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= busReq;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdData_reg <= 32'h0000_0000;
		end else if (busReq) begin
			if (wb_adr_i == `WDT_SETUP_OFS) begin
				rdData_reg <= {27'h0000000, actionLock_reg,
				               runEnable_reg, periodSel_reg,
				               actionSel_reg};
			end else if (wb_adr_i == `WDT_STAT_OFS) begin
				rdData_reg <= {12'h000, inService_reg, pending_reg,
				               active_reg, 17'h00000} |
				              32'(count_reg);
			end else begin
				// command register and holes read zero
				rdData_reg <= 32'h0000_0000;
			end
		end
	end

	// ------------------------------------------------------------------
	// setup register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			runEnable_reg <= `WDT_RUN_RST;
			periodSel_reg <= `WDT_PERIOD_RST;
			actionSel_reg <= `WDT_ACTION_RST;
			actionLock_reg <= 1'b0;
		end else if (setupWr) begin
			runEnable_reg <= wrByte[`WDT_RUN_BIT];
			periodSel_reg <= wrByte[`WDT_PERIOD_MSB:`WDT_PERIOD_LSB];
			// first write after reset fixes the action for good
			if (!actionLock_reg) begin
				actionSel_reg <= wrByte[`WDT_ACTION_BIT];
			end
			actionLock_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// run state
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			active_reg <= 1'b1;
		end else if (setupWr && wrByte[`WDT_RUN_BIT]) begin
			active_reg <= 1'b1;
		end else if (disableCmd) begin
			active_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// prescaler: one tick per low-frequency base period
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			prescale_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else if (prescale_reg == 16'(TICK_DIV - 1)) begin
			prescale_reg <= 16'h0000;
			tick_reg <= 1'b1;
		end else begin
			prescale_reg <= prescale_reg + 16'h0001;
			tick_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// binary counter
	// ------------------------------------------------------------------
	always_comb begin
		case (periodSel_reg)
			2'h0: lastCount = CNT_W'(PERIOD0 - 1);
			2'h1: lastCount = CNT_W'(PERIOD1 - 1);
			2'h2: lastCount = CNT_W'(PERIOD2 - 1);
			default: lastCount = CNT_W'(PERIOD3 - 1);
		endcase
	end

	assign hold = stopMode || idleMode;
	// a clear in the same cycle suppresses the overflow
	assign overflow = active_reg && tick_reg && !hold && !clearCmd &&
	                  (count_reg >= lastCount);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= '0;
		end else if (clearCmd || disableCmd) begin
			count_reg <= '0;
		end else if (overflow) begin
			// wraps and keeps running: periodic in interrupt mode
			count_reg <= '0;
		end else if (active_reg && tick_reg && !hold) begin
			count_reg <= count_reg + CNT_W'(1);
		end
	end

	// ------------------------------------------------------------------
	// pseudo non-maskable interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pending_reg <= 1'b0;
		end else if (overflow && !actionSel_reg) begin
			pending_reg <= 1'b1;
		end else if (irqAccept) begin
			pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			inService_reg <= 1'b0;
		end else if (irqAccept || softIrqAccept) begin
			inService_reg <= 1'b1;
		end else if (nmiReturnDone) begin
			inService_reg <= 1'b0;
		end
	end

	// no mask input at all: the enable mask register cannot gate it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= pending_reg && !inService_reg &&
			           !irqAccept && !softIrqAccept;
		end
	end

	// ------------------------------------------------------------------
	// reset pulse generator
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rstState_reg <= wdt_pkg::RST_IDLE;
			rstCount_reg <= 8'h00;
			sysReset_reg <= 1'b0;
			pinOe_reg <= 1'b0;
			hfOsc_reg <= 1'b0;
		end else begin
			case (rstState_reg)
				wdt_pkg::RST_IDLE: begin
					if (overflow && actionSel_reg) begin
						rstState_reg <= wdt_pkg::RST_DRIVE;
						rstCount_reg <= 8'(RST_CYCLES - 1);
						sysReset_reg <= 1'b1;
						pinOe_reg <= 1'b1;
						hfOsc_reg <= slowMode;
					end
				end
				wdt_pkg::RST_DRIVE: begin
					if (rstCount_reg == 8'h00) begin
						rstState_reg <= wdt_pkg::RST_IDLE;
						sysReset_reg <= 1'b0;
						pinOe_reg <= 1'b0;
						hfOsc_reg <= 1'b0;
					end else begin
						rstCount_reg <= rstCount_reg - 8'h01;
					end
				end
				default: begin
					rstState_reg <= wdt_pkg::RST_IDLE;
				end
			endcase
		end
	end

	// open drain: only ever pulls low
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pinOut_reg <= 1'b0;
		end else begin
			pinOut_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign wb_dat_o = rdData_reg;
	assign wb_ack_o = ack_reg;
	assign watchdogIrq = irq_reg;
	assign sysResetReq = sysReset_reg;
	assign resetPinOut = pinOut_reg;
	assign resetPinOe = pinOe_reg;
	assign hfOscOn = hfOsc_reg;

endmodule

// ---- verif/wdt_watchdog_chk.sv ----
/* Port checker for the watchdog timer unit top module.
 * Assumes core_clk only and a synchronous active-high reset. */
`timescale 1ns/100ps
module wdt_watchdog_chk #(
	parameter int RST_CYCLES = 13
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic slowMode,
	input wire logic irqAccept,
	input wire logic softIrqAccept,
	input wire logic watchdogIrq,
	input wire logic sysResetReq,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	input wire logic hfOscOn
);
	int pulseCnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	// run length of the pulse; repetition would need 13 copies
	always_ff @(posedge core_clk)
		pulseCnt <= (reset || !sysResetReq) ? 0 : pulseCnt + 1;
	a_ack_answer:
		assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered");
	a_ack_once:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_pin_drive:
		assert property (!resetPinOut && resetPinOe == sysResetReq)
		else $error("reset pin drive wrong");
	a_pulse_len:
		assert property ($fell(sysResetReq) && !$past(reset)
			|-> pulseCnt == RST_CYCLES) else $error("pulse length wrong");
	a_pulse_cap:
		assert property (pulseCnt <= RST_CYCLES) else $error("pulse too long");
	a_osc_span:
		assert property (hfOscOn |-> sysResetReq) else $error("osc outside");
	a_osc_slow:
		assert property ($rose(sysResetReq) && $stable(slowMode)
			&& $past(slowMode, 2) == slowMode |-> hfOscOn == slowMode)
		else $error("osc start wrong");
	a_irq_service:
		assert property (irqAccept || softIrqAccept |=> !watchdogIrq [*2])
		else $error("irq during service");
	a_irq_fall:
		assert property ($fell(watchdogIrq) && !$past(reset)
			|-> $past(irqAccept || softIrqAccept))
		else $error("irq dropped unaccepted");
	c_pulse: cover property ($rose(sysResetReq));
	c_irq: cover property ($rose(watchdogIrq));
	c_osc: cover property ($rose(hfOscOn));
endmodule

bind wdt_watchdog_timer wdt_watchdog_chk #(.RST_CYCLES(RST_CYCLES))
	wdt_watchdog_chk_inst (.core_clk, .reset, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .slowMode, .irqAccept, .softIrqAccept, .watchdogIrq,
	.sysResetReq, .resetPinOut, .resetPinOe, .hfOscOn);

// ---- verif/wdt_cpu_model.sv ----
/* CPU side model: takes watchdog interrupts, returns after SVC cycles.
 * Assumes the reset pin net has a pull-up. */
`timescale 1ns/100ps
module wdt_cpu_model #(
	parameter int SVC = 30
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic acceptOn,
	input wire logic softReq,
	input wire logic watchdogIrq,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	output logic irqAccept = 1'b0,
	output logic softIrqAccept = 1'b0,
	output logic nmiReturnDone = 1'b0,
	output logic rstPin,
	output int irqCount = 0
);
	int svcLeft = 0;
	// ------------------------------------------------
	// pin net and service
	// ------------------------------------------------
	assign rstPin = resetPinOe ? resetPinOut : 1'b1;
	always @(posedge core_clk) begin
		irqAccept <= 1'b0;
		softIrqAccept <= 1'b0;
		nmiReturnDone <= 1'b0;
		if (reset) begin
			svcLeft <= 0;
			irqCount <= 0;
		end else if (svcLeft > 0) begin
			svcLeft <= svcLeft - 1;
			nmiReturnDone <= svcLeft == 1;
		end else if (softReq) begin
			softIrqAccept <= 1'b1;
			svcLeft <= SVC;
		end else if (acceptOn && watchdogIrq) begin
			// no mask here: taken when shown while acceptOn is high and no service runs
			irqAccept <= 1'b1;
			svcLeft <= SVC;
			irqCount <= irqCount + 1;
		end
	end
endmodule

// ---- verif/watchdog_timer_unit_tb.sv ----
/* Bench: register table, reset action, guarded disable, interrupt mode.
 * Assumes shortened tick and period parameters. */
`timescale 1ns/100ps
module watchdog_timer_unit_tb;
	typedef struct {
		logic we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wdt_row_t;
	localparam int RSTC = 13;
	logic core_clk = 1'b0, reset = 1'b1, wbReq = 1'b0, wbWe = 1'b0;
	logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
	logic [31:0] wbDatI = 32'h0, wbDatO, d, d1;
	logic wbAck, stopMode = 1'b0, idleMode = 1'b0, slowMode = 1'b0;
	logic acceptOn = 1'b0, softReq = 1'b0, rstPin, hfOscOn;
	logic irqAccept, softIrqAccept, nmiReturnDone, watchdogIrq;
	logic sysResetReq, resetPinOut, resetPinOe;
	int irqCount, fail_count = 0, comparisons = 0, p0, i0;
	int lowLen = 0, oscLen = 0, lastLen = 0, lastOsc = 0, pulses = 0;
	wdt_row_t rows [9] = '{'{1'h0, 4'h0, 4'hf, 32'h09},
		'{1'h1, 4'h0, 4'hf, 32'h0d}, '{1'h0, 4'h0, 4'hf, 32'h1d},
		'{1'h1, 4'h0, 4'hf, 32'h0c}, '{1'h0, 4'h0, 4'hf, 32'h1d},
		'{1'h1, 4'h0, 4'he, 32'h07}, '{1'h0, 4'h0, 4'hf, 32'h1d},
		'{1'h0, 4'h4, 4'hf, 32'h00}, '{1'h0, 4'hc, 4'hf, 32'h00}};
	always #25 core_clk = ~core_clk;
	wdt_watchdog_timer #(.TICK_DIV(2), .PERIOD0(40), .PERIOD1(20),
		.PERIOD2(10), .PERIOD3(5), .RST_CYCLES(RSTC))
		wdt_watchdog_timer_inst (.core_clk, .reset, .wb_cyc_i(wbReq),
		.wb_stb_i(wbReq), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .stopMode, .idleMode, .slowMode, .irqAccept,
		.softIrqAccept, .nmiReturnDone, .watchdogIrq, .sysResetReq,
		.resetPinOut, .resetPinOe, .hfOscOn);
	wdt_cpu_model wdt_cpu_model_inst (.core_clk, .reset, .acceptOn,
		.softReq, .watchdogIrq, .resetPinOut, .resetPinOe, .irqAccept,
		.softIrqAccept, .nmiReturnDone, .rstPin, .irqCount);
	// ------------------------------------------------
	// pin monitor and tasks
	// ------------------------------------------------
	always @(posedge core_clk) begin
		if (rstPin === 1'b0) begin
			lowLen <= lowLen + 1;
			oscLen <= oscLen + hfOscOn;
		end else if (lowLen != 0) begin
			lastLen <= lowLen;
			lastOsc <= oscLen;
			pulses <= pulses + 1;
			lowLen <= 0;
			oscLen <= 0;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic bus(input logic we, input logic [3:0] adr,
			input logic [3:0] sel, input logic [31:0] wd,
			output logic [31:0] rd);
		@(posedge core_clk);
		wbReq <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= sel;
		wbDatI <= wd;
		do begin
			@(posedge core_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbReq <= 1'b0;
	endtask
	task automatic do_reset;
		reset <= 1'b1;
		tick(10);
		reset <= 1'b0;
	endtask
	task automatic close_out;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// run is under 800 cycles; the guard allows about four times that
	initial begin
		tick(3000);
		fail_count++;
		close_out();
	end
	initial begin
		do_reset();
		foreach (rows[i]) begin
			bus(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat, d);
			if (!rows[i].we)
				chk(d, rows[i].dat);
		end
		do_reset();
		bus(1'h1, 4'h0, 4'hf, 32'h0d, d);
		bus(1'h1, 4'h4, 4'hf, 32'h4e, d);
		p0 = pulses;
		repeat (8) begin
			tick(4);
			bus(1'h1, 4'h4, 4'hf, 32'h4e, d);
		end
		stopMode <= 1'b1;
		bus(1'h0, 4'h8, 4'hf, 32'h0, d1);
		tick(20);
		stopMode <= 1'b0;
		idleMode <= 1'b1;
		bus(1'h0, 4'h8, 4'hf, 32'h0, d);
		chk({15'h0, d[16:0]}, {15'h0, d1[16:0]});
		idleMode <= 1'b0;
		chk(pulses - p0, 0);
		slowMode <= 1'b1;
		repeat (4)
			bus(1'h1, 4'h4, 4'hf, 32'h55, d);
		bus(1'h0, 4'h8, 4'hf, 32'h0, d);
		chk(32'(d[16:0] >= 17'h00004), 32'h1);
		repeat (80)
			if (pulses == p0)
				@(posedge core_clk);
		chk(pulses - p0, 1);
		chk(lastLen, RSTC);
		chk(lastOsc, RSTC);
		slowMode <= 1'b0;
		do_reset();
		d = {28'h0, sysResetReq, resetPinOe, watchdogIrq, hfOscOn};
		chk(d, 32'h0);
		tick(6);
		bus(1'h1, 4'h4, 4'hf, 32'hb1, d);
		bus(1'h0, 4'h8, 4'hf, 32'h0, d);
		chk({31'h0, d[17]}, 32'h1);
		bus(1'h1, 4'h4, 4'hf, 32'h4e, d);
		bus(1'h1, 4'h0, 4'hf, 32'h01, d);
		bus(1'h1, 4'h4, 4'hf, 32'hb1, d);
		bus(1'h0, 4'h8, 4'hf, 32'h0, d);
		chk({14'h0, d[17:0]}, 32'h0);
		p0 = pulses;
		tick(120);
		chk(pulses - p0, 0);
		bus(1'h1, 4'h0, 4'hf, 32'h09, d);
		bus(1'h0, 4'h8, 4'hf, 32'h0, d);
		chk({31'h0, d[17]}, 32'h1);
		do_reset();
		acceptOn <= 1'b1;
		bus(1'h1, 4'h0, 4'hf, 32'h0e, d);
		bus(1'h0, 4'h0, 4'hf, 32'h0, d);
		chk(d, 32'h1e);
		p0 = pulses;
		i0 = irqCount;
		tick(100);
		acceptOn <= 1'b0;
		tick(40);
		softReq <= 1'b1;
		tick(1);
		softReq <= 1'b0;
		acceptOn <= 1'b1;
		tick(100);
		chk(32'(irqCount - i0 >= 3), 32'h1);
		chk(pulses - p0, 0);
		close_out();
	end
endmodule
